// >>> lcd_port_regs.svh
// Constants for the LCD host write port: pin fields, host register map, timing.
// Assumes inclusion by bare name from the design files of both ends.
//
// Contract
// - Parallel strap high lets bus style pick convention.
// - Bus style high selects 68-style enable strobe.
// - Straps pick 8-bit, 4-bit on D7-D4, serial.
// - 4-bit mode carries each byte as two nibbles.
// - Host spaces writes by the system cycle time.
// - Serial path: shift register, 3-bit counter, selected only.
// - Deselection clears shift register and bit counter.
// - Serial bits MSB first on rising serial clock.
// - Eighth rising serial clock delivers the byte.
// - Select high means display data, low command.
// - Select sampled on every eighth serial clock.
// - Parallel write routes by select: data or command.
// - Deselected device ignores all host inputs.
// - Reset acts regardless of chip select.
// - Host rewrites command settings periodically.
// - Power command switches booster, regulator, follower separately.
// - Host uses only supported power combinations.
`ifndef LCD_PORT_REGS_SVH
`define LCD_PORT_REGS_SVH

// ====================================================================
// Pin fields on the data bus in serial mode
`define LCD_SI_BIT 7
`define LCD_SCL_BIT 6

// ====================================================================
// Power control command: opcode in the upper nibble, enables below
`define LCD_PWR_OP 4'h2
`define LCD_PWR_BOOST_BIT 2
`define LCD_PWR_REG_BIT 1
`define LCD_PWR_FOLLOW_BIT 0

// ====================================================================
// Host controller registers
`define LCD_CTRL_OFS 4'h0
`define LCD_TX_OFS 4'h4
`define LCD_STAT_OFS 4'h8
`define LCD_CTRL_PAR_BIT 0
`define LCD_CTRL_W8_BIT 1
`define LCD_CTRL_S68_BIT 2
`define LCD_CTRL_RST 3'h3
`define LCD_TX_CDS_BIT 8
`define LCD_STAT_BUSY_BIT 0
`define LCD_STAT_DROP_BIT 1

// ====================================================================
// Timing
`define LCD_CLK_MHZ 50
`define LCD_HALF_NS 80

`endif

// >>> lcd_port_pkg.sv
// Types shared by both ends of the LCD host write port.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package lcd_port_pkg;
	typedef enum logic [2:0] {H_IDLE, H_LO, H_HI, H_TAIL, H_GAP} host_state_e;
	typedef logic [7:0] byte_t;
endpackage : lcd_port_pkg
`default_nettype wire

// >>> lcd_port_if.sv
// Pins between host controller and LCD device port; all driven by the host.
// Assumes both ends run on their own clocks; the device synchronises every pin.
`timescale 1ns/1ps
`default_nettype none
interface lcd_port_if;
	logic cs_n;
	logic cmd_data_sel;
	logic wr;
	logic [7:0] d;
	logic par_ser_strap;
	logic width_strap;
	logic bus_style_strap;
	modport host (
		output cs_n, cmd_data_sel, wr, d, par_ser_strap, width_strap, bus_style_strap
	);
	modport device (
		input cs_n, cmd_data_sel, wr, d, par_ser_strap, width_strap, bus_style_strap
	);
endinterface : lcd_port_if
`default_nettype wire

// >>> lcd_byte_fifo.sv
// Flop-based FIFO with valid/ready on both sides.
// Assumes one clock; a full FIFO holds in_ready low.
`timescale 1ns/1ps
`default_nettype none
module lcd_byte_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q, rp_q, wp_d, rp_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	always_comb begin
		in_ready = (cnt_q != (AW+1)'(DEPTH));
		out_valid = (cnt_q != '0);
		push = in_valid & in_ready;
		pop = out_valid & out_ready;
		wp_d = push ? wp_q + AW'(1) : wp_q;
		rp_d = pop ? rp_q + AW'(1) : rp_q;
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		out_data = mem_q[rp_q];
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
		end
	end

	// Storage has no reset; only the pointers and the count need a defined value.
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end
endmodule : lcd_byte_fifo
`default_nettype wire

// >>> lcd_dev_end.sv
// Device end of the LCD host write port: decodes parallel 8/4-bit and serial
// writes into command and display bytes, queues them, and keeps power enables.
// Assumes all link pins are asynchronous to clk; the link clock runs well
// below clk so every pin level lasts several clk cycles.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_port_regs.svh"
module lcd_dev_end #(
	parameter int FIFO_DEPTH = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Link pins
	lcd_port_if.device link,
	// Received byte stream
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [7:0] rx_data,
	output logic rx_is_data,
	// Power circuit enables
	output logic booster_on,
	output logic regulator_on,
	output logic follower_on,
	// Overrun flag and its clear
	output logic overrun,
	input wire logic overrun_clr
);
	// ====================================================================
	// Pin synchronisers
	localparam int SW = 14;
	logic [SW-1:0] s1_q, s2_q, pins;

	always_comb begin
		pins = {link.par_ser_strap, link.width_strap, link.bus_style_strap,
			link.cs_n, link.cmd_data_sel, link.wr, link.d};
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s1_q <= '1;
			s2_q <= '1;
		end else begin
			s1_q <= pins;
			s2_q <= s1_q;
		end
	end

	logic par, w8, s68, sel, cds, wr_pin;
	logic [7:0] dat;

	always_comb begin
		par = s2_q[13];
		w8 = s2_q[12];
		s68 = s2_q[11];
		sel = ~s2_q[10];
		cds = s2_q[9];
		wr_pin = s2_q[8];
		dat = s2_q[7:0];
	end

	// ====================================================================
	// Byte assembly
	logic act, scl;
	logic act_q, act_d, scl_q, scl_d;
	logic [7:0] hold_q, hold_d;
	logic ha0_q, ha0_d;
	logic [6:0] sh_q, sh_d;
	logic [2:0] bcnt_q, bcnt_d;
	logic nib_q, nib_d;
	logic [3:0] upper_q, upper_d;
	logic pend_q, pend_d;
	lcd_port_pkg::byte_t pbyte_q, pbyte_d;
	logic pa0_q, pa0_d;
	logic ovr_q, ovr_d;
	logic boost_q, boost_d, reg_q, reg_d, fol_q, fol_d;
	logic emit, ea0;
	lcd_port_pkg::byte_t eb;
	logic fifo_in_ready, fifo_out_valid;
	logic [8:0] fifo_out;
	logic pop;

	always_comb begin
		// 68-style enable is active high, 80-style write strobe active low.
		act = s68 ? wr_pin : ~wr_pin;
		scl = dat[`LCD_SCL_BIT];
		act_d = act & sel;
		scl_d = scl & sel;
		hold_d = hold_q;
		ha0_d = ha0_q;
		sh_d = sh_q;
		bcnt_d = bcnt_q;
		nib_d = nib_q;
		upper_d = upper_q;
		pend_d = pend_q;
		pbyte_d = pbyte_q;
		pa0_d = pa0_q;
		ovr_d = ovr_q;
		emit = 1'b0;
		eb = '0;
		ea0 = 1'b0;
		if (pend_q && fifo_in_ready) begin
			pend_d = 1'b0;
		end
		if (!sel) begin
			// Deselection throws away any half-received byte.
			sh_d = '0;
			bcnt_d = '0;
			nib_d = 1'b0;
		end else if (par) begin
			// Data is caught while the strobe is active and used at its end,
			// since the host may change the bus on the same edge.
			if (act) begin
				hold_d = dat;
				ha0_d = cds;
			end
			if (act_q && !act) begin
				if (w8) begin
					emit = 1'b1;
					eb = hold_q;
					ea0 = ha0_q;
				end else if (!nib_q) begin
					upper_d = hold_q[7:4];
					nib_d = 1'b1;
				end else begin
					emit = 1'b1;
					eb = {upper_q, hold_q[7:4]};
					ea0 = ha0_q;
					nib_d = 1'b0;
				end
			end
		end else if (scl && !scl_q) begin
			// Serial mode ignores the width strap.
			sh_d = {sh_q[5:0], dat[`LCD_SI_BIT]};
			bcnt_d = bcnt_q + 3'h1;
			if (bcnt_q == 3'h7) begin
				emit = 1'b1;
				eb = {sh_q, dat[`LCD_SI_BIT]};
				ea0 = cds;
			end
		end
		if (emit) begin
			if (pend_d) begin
				ovr_d = 1'b1;
			end else begin
				pend_d = 1'b1;
				pbyte_d = eb;
				pa0_d = ea0;
			end
		end else if (overrun_clr) begin
			ovr_d = 1'b0;
		end
		// Power commands take effect as they leave the queue, so they keep
		// their order relative to the display data around them.
		pop = fifo_out_valid & rx_ready;
		boost_d = boost_q;
		reg_d = reg_q;
		fol_d = fol_q;
		if (pop && !fifo_out[8] && fifo_out[7:4] == `LCD_PWR_OP) begin
			boost_d = fifo_out[`LCD_PWR_BOOST_BIT];
			reg_d = fifo_out[`LCD_PWR_REG_BIT];
			fol_d = fifo_out[`LCD_PWR_FOLLOW_BIT];
		end
	end

	// Asynchronous reset acts whatever the chip select does.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			act_q <= 1'b0;
			scl_q <= 1'b0;
			hold_q <= 8'h00;
			ha0_q <= 1'b0;
			sh_q <= 7'h00;
			bcnt_q <= 3'h0;
			nib_q <= 1'b0;
			upper_q <= 4'h0;
			pend_q <= 1'b0;
			pbyte_q <= 8'h00;
			pa0_q <= 1'b0;
			ovr_q <= 1'b0;
			boost_q <= 1'b0;
			reg_q <= 1'b0;
			fol_q <= 1'b0;
		end else begin
			act_q <= act_d;
			scl_q <= scl_d;
			hold_q <= hold_d;
			ha0_q <= ha0_d;
			sh_q <= sh_d;
			bcnt_q <= bcnt_d;
			nib_q <= nib_d;
			upper_q <= upper_d;
			pend_q <= pend_d;
			pbyte_q <= pbyte_d;
			pa0_q <= pa0_d;
			ovr_q <= ovr_d;
			boost_q <= boost_d;
			reg_q <= reg_d;
			fol_q <= fol_d;
		end
	end

	// ====================================================================
	// Queue between link and consumer
	lcd_byte_fifo #(
		.WIDTH(9),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.in_valid(pend_q),
		.in_ready(fifo_in_ready),
		.in_data({pa0_q, pbyte_q}),
		.out_valid(fifo_out_valid),
		.out_ready(rx_ready),
		.out_data(fifo_out)
	);

	always_comb begin
		rx_valid = fifo_out_valid;
		rx_data = fifo_out[7:0];
		rx_is_data = fifo_out[8];
		booster_on = boost_q;
		regulator_on = reg_q;
		follower_on = fol_q;
		overrun = ovr_q;
	end
endmodule : lcd_dev_end
`default_nettype wire

// >>> lcd_host_end.sv
// Host end: takes bytes from software registers and writes them to the LCD
// device in 8-bit, 4-bit or serial form, making the strobe or serial clock.
// Assumes a single-cycle register port; software keeps power commands legal
// and refreshes settings itself.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_port_regs.svh"
module lcd_host_end (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [15:0] rdata,
	// Link pins
	lcd_port_if.host link
);
	// Half link period, rounded up to whole cycles.
	localparam int HALF_CYC = (`LCD_HALF_NS * `LCD_CLK_MHZ + 999) / 1000;

	function automatic logic [7:0] present(input logic [7:0] b, input logic ser,
			input logic w8);
		if (ser) begin
			present = {b[7], 7'h00};
		end else if (w8) begin
			present = b;
		end else begin
			present = {b[7:4], 4'h0};
		end
	endfunction : present

	lcd_port_pkg::host_state_e st_q, st_d;
	logic [7:0] div_q, div_d;
	logic [2:0] unit_q, unit_d, last;
	logic [7:0] sh_q, sh_d, dout_q, dout_d;
	logic cds_q, cds_d, cs_n_q, cs_n_d, act_q, act_d, drop_q, drop_d;
	logic [2:0] ctrl_q, ctrl_d;
	logic [15:0] rdata_q, rdata_d;
	logic tick, ser, w8, tx_wr;

	always_comb begin
		st_d = st_q;
		unit_d = unit_q;
		sh_d = sh_q;
		dout_d = dout_q;
		cds_d = cds_q;
		cs_n_d = cs_n_q;
		act_d = act_q;
		drop_d = drop_q;
		ctrl_d = ctrl_q;
		rdata_d = 16'h0000;
		ser = ~ctrl_q[`LCD_CTRL_PAR_BIT];
		w8 = ctrl_q[`LCD_CTRL_W8_BIT];
		last = ser ? 3'h7 : (w8 ? 3'h0 : 3'h1);
		tick = (div_q == 8'(HALF_CYC - 1));
		div_d = (tick || st_q == lcd_port_pkg::H_IDLE) ? 8'h00 : div_q + 8'h01;
		tx_wr = wr_stb && addr == `LCD_TX_OFS;
		if (wr_stb && addr == `LCD_CTRL_OFS && st_q == lcd_port_pkg::H_IDLE) begin
			ctrl_d = wdata[2:0];
		end
		if (wr_stb && addr == `LCD_STAT_OFS && wdata[`LCD_STAT_DROP_BIT]) begin
			drop_d = 1'b0;
		end
		case (st_q)
			lcd_port_pkg::H_IDLE: begin
				if (tx_wr) begin
					sh_d = wdata[7:0];
					cds_d = wdata[`LCD_TX_CDS_BIT];
					dout_d = present(wdata[7:0], ser, w8);
					unit_d = 3'h0;
					cs_n_d = 1'b0;
					st_d = lcd_port_pkg::H_LO;
				end
			end
			lcd_port_pkg::H_LO: begin
				// The next unit goes out one cycle after the strobe or clock
				// falls, so data never moves together with the strobe.
				if (div_q == 8'h00) begin
					dout_d = present(sh_q, ser, w8);
				end
				if (tick) begin
					if (ser) begin
						dout_d[`LCD_SCL_BIT] = 1'b1;
					end else begin
						act_d = 1'b1;
					end
					st_d = lcd_port_pkg::H_HI;
				end
			end
			lcd_port_pkg::H_HI: begin
				if (tick) begin
					act_d = 1'b0;
					dout_d[`LCD_SCL_BIT] = ser ? 1'b0 : dout_q[`LCD_SCL_BIT];
					if (unit_q == last) begin
						st_d = lcd_port_pkg::H_TAIL;
					end else begin
						sh_d = ser ? {sh_q[6:0], 1'b0} : {sh_q[3:0], 4'h0};
						unit_d = unit_q + 3'h1;
						st_d = lcd_port_pkg::H_LO;
					end
				end
			end
			lcd_port_pkg::H_TAIL: begin
				if (tick) begin
					cs_n_d = 1'b1;
					st_d = lcd_port_pkg::H_GAP;
				end
			end
			lcd_port_pkg::H_GAP: begin
				// One idle half period keeps successive writes apart.
				if (tick) begin
					// Idle lines rest at zero so a later mode change sees no stale bits.
					dout_d = 8'h00;
					st_d = lcd_port_pkg::H_IDLE;
				end
			end
			default: begin
				st_d = lcd_port_pkg::H_IDLE;
			end
		endcase
		if (tx_wr && st_q != lcd_port_pkg::H_IDLE) begin
			drop_d = 1'b1;
		end
		if (rd_stb) begin
			case (addr)
				`LCD_CTRL_OFS: rdata_d = {13'h0000, ctrl_q};
				`LCD_STAT_OFS: rdata_d = {14'h0000, drop_q, st_q != lcd_port_pkg::H_IDLE};
				default: rdata_d = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= lcd_port_pkg::H_IDLE;
			div_q <= 8'h00;
			unit_q <= 3'h0;
			sh_q <= 8'h00;
			dout_q <= 8'h00;
			cds_q <= 1'b0;
			cs_n_q <= 1'b1;
			act_q <= 1'b0;
			drop_q <= 1'b0;
			ctrl_q <= `LCD_CTRL_RST;
			rdata_q <= 16'h0000;
		end else begin
			st_q <= st_d;
			div_q <= div_d;
			unit_q <= unit_d;
			sh_q <= sh_d;
			dout_q <= dout_d;
			cds_q <= cds_d;
			cs_n_q <= cs_n_d;
			act_q <= act_d;
			drop_q <= drop_d;
			ctrl_q <= ctrl_d;
			rdata_q <= rdata_d;
		end
	end

	always_comb begin
		rdata = rdata_q;
		link.cs_n = cs_n_q;
		link.cmd_data_sel = cds_q;
		link.wr = ctrl_q[`LCD_CTRL_S68_BIT] ? act_q : ~act_q;
		link.d = dout_q;
		link.par_ser_strap = ctrl_q[`LCD_CTRL_PAR_BIT];
		link.width_strap = ctrl_q[`LCD_CTRL_W8_BIT];
		link.bus_style_strap = ctrl_q[`LCD_CTRL_S68_BIT];
	end
endmodule : lcd_host_end
`default_nettype wire

// >>> lcd_port_props.sv
// Checker of the pins between the host end and the device end of the LCD port.
// Assumes the bench wires the interface signals to it by name.
`timescale 1ns/1ps
`default_nettype none
module lcd_port_props (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Link pins
	input wire logic cs_n,
	input wire logic cmd_data_sel,
	input wire logic wr,
	input wire logic [7:0] d,
	input wire logic par_ser_strap,
	input wire logic width_strap,
	input wire logic bus_style_strap
);
	// ====================================================================
	// Serial clock rises and nibble strobes seen within one selection.
	logic [2:0] scl_cnt_q, scl_cnt_d;
	logic nib_q, nib_d, scl_q, wr_q;
	logic strobe_end;
	always_comb begin
		strobe_end = bus_style_strap ? (wr_q && !wr) : (wr && !wr_q);
		scl_cnt_d = scl_cnt_q;
		nib_d = nib_q;
		if (cs_n) begin
			scl_cnt_d = 3'h0;
			nib_d = 1'b0;
		end else begin
			if (!par_ser_strap && d[6] && !scl_q) scl_cnt_d = scl_cnt_q + 3'h1;
			if (par_ser_strap && !width_strap && strobe_end) nib_d = !nib_q;
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_cnt_q <= 3'h0;
			nib_q <= 1'b0;
			scl_q <= 1'b0;
			wr_q <= 1'b1;
		end else begin
			scl_cnt_q <= scl_cnt_d;
			nib_q <= nib_d;
			scl_q <= d[6];
			wr_q <= wr;
		end
	end
	// ====================================================================
	// Pin relations.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_wr_sel; (par_ser_strap && !bus_style_strap && !wr) |-> !cs_n; endproperty
	a_wr_sel: assert property (p_wr_sel) else $error("write strobe outside selection");
	property p_e_sel; (par_ser_strap && bus_style_strap && wr) |-> !cs_n; endproperty
	a_e_sel: assert property (p_e_sel) else $error("enable strobe outside selection");
	property p_scl_sel; (!par_ser_strap && d[6]) |-> !cs_n; endproperty
	a_scl_sel: assert property (p_scl_sel) else $error("serial clock outside selection");
	property p_nib_low; (par_ser_strap && !width_strap) |-> d[3:0] == 4'h0; endproperty
	a_nib_low: assert property (p_nib_low) else $error("low lines busy in 4-bit mode");
	property p_ser_rest; !par_ser_strap |-> d[5:0] == 6'h00; endproperty
	a_ser_rest: assert property (p_ser_rest) else $error("unused lines busy in serial mode");
	property p_strap_hold;
		!cs_n |=> $stable({par_ser_strap, width_strap, bus_style_strap});
	endproperty
	a_strap_hold: assert property (p_strap_hold) else $error("straps moved while selected");
	property p_d_hold;
		(par_ser_strap && !bus_style_strap && !cs_n && !wr) |=> $stable(d) && $stable(cmd_data_sel);
	endproperty
	a_d_hold: assert property (p_d_hold) else $error("data moved during write strobe");
	property p_si_hold; (!par_ser_strap && !cs_n && d[6]) |=> !d[6] || $stable(d[7]); endproperty
	a_si_hold: assert property (p_si_hold) else $error("serial data moved with clock high");
	property p_scl_len; (!par_ser_strap && $rose(d[6])) |=> d[6] [*3] ##1 !d[6]; endproperty
	a_scl_len: assert property (p_scl_len) else $error("serial clock high phase wrong");
	property p_ser_eight; (!par_ser_strap && $rose(cs_n)) |-> scl_cnt_q == 3'h0; endproperty
	a_ser_eight: assert property (p_ser_eight) else $error("serial frame not whole bytes");
	property p_nib_pair; (par_ser_strap && !width_strap && $rose(cs_n)) |-> !nib_q; endproperty
	a_nib_pair: assert property (p_nib_pair) else $error("odd nibble count in frame");
	property p_gap; $rose(cs_n) |=> cs_n [*3]; endproperty
	a_gap: assert property (p_gap) else $error("deselect gap too short");
endmodule : lcd_port_props
`default_nettype wire

// >>> lcd_host_write_port_bench.sv
// Bench for the LCD host write port: host end and device end joined by the link.
// Assumes the design files and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_port_regs.svh"
module lcd_host_write_port_bench;
	logic clk, reset_n, wr_stb, rd_stb, rx_ready, overrun_clr;
	logic [3:0] addr;
	logic [15:0] wdata, rdata, got;
	logic rx_valid, rx_is_data, booster_on, regulator_on, follower_on, overrun;
	logic [7:0] rx_data;
	int miscompares, checks_done;
	lcd_port_if link_if();
	lcd_host_end u_lcd_host_end (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .link(link_if));
	lcd_dev_end #(.FIFO_DEPTH(32)) u_lcd_dev_end (.clk(clk), .reset_n(reset_n), .link(link_if),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_is_data(rx_is_data),
		.booster_on(booster_on), .regulator_on(regulator_on), .follower_on(follower_on),
		.overrun(overrun), .overrun_clr(overrun_clr));
	lcd_port_props u_lcd_port_props (.clk(clk), .reset_n(reset_n), .cs_n(link_if.cs_n),
		.cmd_data_sel(link_if.cmd_data_sel), .wr(link_if.wr), .d(link_if.d),
		.par_ser_strap(link_if.par_ser_strap), .width_strap(link_if.width_strap),
		.bus_style_strap(link_if.bus_style_strap));
	// ====================================================================
	// Shared tasks.
	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic reg_wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask : reg_wr
	task automatic reg_rd(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1 got = rdata;
	endtask : reg_rd
	task automatic send(input logic [8:0] tx);
		reg_wr(`LCD_TX_OFS, {7'h00, tx});
		got = 16'h0001;
		for (int n = 0; n < 200 && got[0] !== 1'b0; n++) reg_rd(`LCD_STAT_OFS);
		check("busy", 16'h0000, {15'h0000, got[0]});
	endtask : send
	task automatic take(input logic [7:0] b, input logic is_data);
		@(negedge clk);
		for (int n = 0; n < 60 && rx_valid !== 1'b1; n++) @(negedge clk);
		check("rx_valid", 16'h0001, {15'h0000, rx_valid});
		check("rx_byte", {7'h00, is_data, b}, {7'h00, rx_is_data, rx_data});
		@(posedge clk);
		rx_ready <= 1'b1;
		@(posedge clk);
		rx_ready <= 1'b0;
	endtask : take
	// ====================================================================
	// Scenarios.
	task automatic t_regs();
		reg_rd(`LCD_CTRL_OFS); check("ctrl", 16'h0003, got);
		reg_rd(4'hC); check("unmapped", 16'h0000, got);
		reg_rd(`LCD_TX_OFS); check("tx_read", 16'h0000, got);
	endtask : t_regs
	task automatic t_modes();
		logic [2:0] modes [5] = '{3'h3, 3'h7, 3'h1, 3'h5, 3'h0};
		for (int i = 0; i < 5; i++) begin
			reg_wr(`LCD_CTRL_OFS, {13'h0000, modes[i]});
			send({1'b1, 8'hA5 + 8'(i)}); take(8'hA5 + 8'(i), 1'b1);
			send({1'b0, ~(8'hA5 + 8'(i))}); take(~(8'hA5 + 8'(i)), 1'b0);
		end
	endtask : t_modes
	task automatic t_power();
		logic [2:0] sets [5] = '{3'h7, 3'h3, 3'h1, 3'h0, 3'h0};
		reg_wr(`LCD_CTRL_OFS, 16'h0003);
		for (int i = 0; i < 5; i++) begin
			send({1'b0, `LCD_PWR_OP, 1'b0, sets[i]});
			take({`LCD_PWR_OP, 1'b0, sets[i]}, 1'b0);
			repeat (3) @(negedge clk);
			check("power", {13'h0000, sets[i]}, {13'h0000, booster_on, regulator_on, follower_on});
		end
	endtask : t_power
	task automatic t_drop();
		reg_wr(`LCD_TX_OFS, 16'h01C3);
		send(9'h13C);
		reg_rd(`LCD_STAT_OFS); check("drop", 16'h0002, got);
		reg_wr(`LCD_STAT_OFS, 16'h0002);
		reg_rd(`LCD_STAT_OFS); check("drop_clear", 16'h0000, got);
		take(8'hC3, 1'b1);
		repeat (20) @(negedge clk);
		check("rx_empty", 16'h0000, {15'h0000, rx_valid});
	endtask : t_drop
	task automatic t_fill();
		for (int i = 0; i < 34; i++) send({1'b1, 8'(i)});
		check("overrun", 16'h0001, {15'h0000, overrun});
		for (int i = 0; i < 33; i++) take(8'(i), 1'b1);
		repeat (20) @(negedge clk);
		check("drained", 16'h0000, {15'h0000, rx_valid});
		@(posedge clk);
		overrun_clr <= 1'b1;
		@(posedge clk);
		overrun_clr <= 1'b0;
		#1 check("overrun_clr", 16'h0000, {15'h0000, overrun});
	endtask : t_fill
	task automatic t_reset();
		send(9'h1E7);
		reg_wr(`LCD_TX_OFS, 16'h0118);
		repeat (6) @(posedge clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(negedge clk);
		check("rx_after_reset", 16'h0000, {15'h0000, rx_valid});
		reg_rd(`LCD_STAT_OFS); check("stat_after_reset", 16'h0000, got);
		send(9'h124); take(8'h24, 1'b1);
	endtask : t_reset
	// ====================================================================
	// Verdict, clock, watchdog and main sequence.
	task automatic print_verdict();
		if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : print_verdict
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#500us;
		miscompares++;
		print_verdict();
	end
	initial begin
		{reset_n, wr_stb, rd_stb, rx_ready, overrun_clr} = 5'h00;
		addr = 4'h0;
		wdata = 16'h0000;
		miscompares = 0;
		checks_done = 0;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		t_regs();
		t_modes();
		t_power();
		t_drop();
		t_fill();
		t_reset();
		print_verdict();
	end
endmodule : lcd_host_write_port_bench
`default_nettype wire
